// File: hdl/pmsrp_cfg.svh
// Constants of the supervisor: register map, field positions, reset values and timing
`ifndef PMSRP_CFG_SVH
`define PMSRP_CFG_SVH
`define PMSRP_CLK_MHZ        200
`define PMSRP_REL_DELAY_MS   65
`define PMSRP_REL_CYCLES     (`PMSRP_REL_DELAY_MS * 1000 * `PMSRP_CLK_MHZ)
`define PMSRP_PG_BLANK_NS    1000
`define PMSRP_PG_BLANK_CYC   ((`PMSRP_PG_BLANK_NS * `PMSRP_CLK_MHZ) / 1000)
`define PMSRP_SLEW_CYC       64
`define PMSRP_ADDR_CTRL      12'h000
`define PMSRP_ADDR_CORE      12'h004
`define PMSRP_ADDR_CARD      12'h008
`define PMSRP_ADDR_STATUS    12'h00C
`define PMSRP_ADDR_ID        12'h010
`define PMSRP_CORE_W         5
`define PMSRP_CARD_W         2
`define PMSRP_CORE_DEF       5'h18
`define PMSRP_CARD_DEF       2'h0
`define PMSRP_CTRL_DEF       6'h00
`define PMSRP_ID_VALUE       32'h0000_5A01
`define PMSRP_NRAILS         6
`define PMSRP_CORE_IDX       2
`define PMSRP_CARD_IDX       5
`endif

// File: hdl/pmsrp_pkg.sv
// Types shared by the supervisor modules
package pmsrp_pkg;
    typedef enum logic [1:0] {
        PMSRP_RST_HOLD,
        PMSRP_RST_COUNT,
        PMSRP_RST_OFF
    } pmsrp_rst_e;
    typedef logic [5:0] pmsrp_rails_t;
endpackage : pmsrp_pkg

// File: hdl/pmsrp_sync_if.sv
// Interface carrying synchronised comparator levels between supervisor modules
`timescale 1ns/100ps
interface pmsrp_sync_if;
    logic       lockout;
    logic       vin_hi;
    logic       aon_ok;
    logic       mr_n;
    logic       backup_ok;
    logic       dead_cmp;
    logic       low_cmp;
    logic [5:0] rail_ok;
    logic [5:0] rail_en;
    modport src (output lockout, vin_hi, aon_ok, mr_n, backup_ok, dead_cmp, low_cmp, rail_ok, rail_en);
    modport dst (input  lockout, vin_hi, aon_ok, mr_n, backup_ok, dead_cmp, low_cmp, rail_ok, rail_en);
endinterface : pmsrp_sync_if

// File: hdl/pmsrp_sync.sv
// Two-flop synchronisers for every comparator and pin level entering the block
`timescale 1ns/100ps
module pmsrp_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic [24:0] raw,
    pmsrp_sync_if.src s
);
    logic [24:0] meta_r;
    logic [24:0] stab_r;
    logic [24:0] meta_nxt;
    logic [24:0] stab_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = raw;
        stab_nxt = meta_r;
    end

    // Reset to safe levels: locked out, no rails; manual reset idle so no false edge follows reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 25'h000_0009;
            stab_r <= 25'h000_0009;
        end else begin
            meta_r <= meta_nxt;
            stab_r <= stab_nxt;
        end
    end

    assign s.lockout   = stab_r[0];
    assign s.vin_hi    = stab_r[1];
    assign s.aon_ok    = stab_r[2];
    assign s.mr_n      = stab_r[3];
    assign s.backup_ok = stab_r[4];
    assign s.dead_cmp  = stab_r[5];
    assign s.low_cmp   = stab_r[6];
    assign s.rail_ok   = stab_r[12:7];
    assign s.rail_en   = stab_r[18:13];
endmodule : pmsrp_sync

// File: hdl/pmsrp_pg.sv
// Power-good aggregation over the six switchable rails with enable and slew masking
`timescale 1ns/100ps
`include "pmsrp_cfg.svh"
module pmsrp_pg #(
    parameter int BLANK = `PMSRP_PG_BLANK_CYC
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    pmsrp_sync_if.dst       s,
    input  wire logic       core_slew,
    output logic            pg_good
);
    logic [5:0]  en_d_r;
    logic [5:0]  en_d_nxt;
    logic [15:0] blank_r;
    logic [15:0] blank_nxt;
    logic [5:0]  mask;

    // Blank after any rail turns on so power-good dips even if the comparator is slow
    always_comb begin
        en_d_nxt  = s.rail_en;
        blank_nxt = blank_r;
        if (|(s.rail_en & ~en_d_r)) begin
            blank_nxt = 16'(BLANK);
        end else if (blank_r != 16'h0000) begin
            blank_nxt = blank_r - 16'h0001;
        end
        mask = s.rail_en;
        if (core_slew) begin
            mask[`PMSRP_CORE_IDX] = 1'b0;
        end
        pg_good = !s.lockout && (|s.rail_en) && (blank_r == 16'h0000) && ((s.rail_ok & mask) == mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_d_r  <= 6'h00;
            blank_r <= 16'h0000;
        end else begin
            en_d_r  <= en_d_nxt;
            blank_r <= blank_nxt;
        end
    end
endmodule : pmsrp_pg

// File: hdl/pmsrp_top.sv
// Supervisor top: reset timer, manual reset, battery flags, power-good and AHB-Lite registers
// Function
// RL1: In input lockout the functions are disabled and pins undriven; the outputs stay driven while backup is present, flags high and power-good low.
// RL2: Programmed settings survive lockout; only manual reset or bus reset changes them.
// RL3: Reset output low while manual reset low or always-on rail low.
// RL4: With input above 2.4V, reset released 65ms after always-on rail good.
// RL5: Input low at always-on rise, or both together, releases reset immediately.
// RL6: Reset output depends only on always-on rail and manual reset.
// RL7: No backup supply leaves reset, battery flags and power-good undriven.
// RL8: Manual reset asserts reset 65ms, core to 1.3V, card rail off.
// RL9: Dead-battery flag follows the dead-battery comparator.
// RL10: Low-battery flag follows the low-battery comparator.
// RL11: Power-good low while any enabled rail is out of regulation.
// RL12: Always-on rail is excluded from power-good.
// RL13: Core slewing and disabled rails are masked from power-good.
// RL14: Enabling a rail pulls power-good low until it regulates.
// RL15: All six rails disabled forces power-good low.
// RL16: Power-good held low during input lockout.
// RL17: No internal sequencing; each rail follows its own enable.
// RL18: Core code spans 0.7V to 1.475V in 25mV steps, default 1.3V.
// RL19: Card rail setting defaults to off.
// RL20: Release delay is a counter restarted by any reset cause.
// RL21: Long manual reset holds reset, then full delay after release.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pmsrp_cfg.svh"
module pmsrp_top
    import pmsrp_pkg::*;
#(
    parameter int unsigned REL_CYCLES = `PMSRP_REL_CYCLES,
    parameter int unsigned PG_BLANK   = `PMSRP_PG_BLANK_CYC,
    parameter int unsigned SLEW_CYC   = `PMSRP_SLEW_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        input_lockout,
    input  wire logic        vin_above_2v4,
    input  wire logic        always_on_rail_ok,
    input  wire logic        manual_reset_n,
    input  wire logic        backup_supply,
    input  wire logic        dead_batt_sense,
    input  wire logic        low_batt_sense,
    input  wire logic [5:0]  rail_in_reg,
    input  wire logic [5:0]  rail_enable,
    output logic             reset_out_n_o,
    output logic             reset_out_n_oe,
    output logic             dead_batt_flag_n_o,
    output logic             dead_batt_flag_n_oe,
    output logic             low_batt_flag_n_o,
    output logic             low_batt_flag_n_oe,
    output logic             power_good_o,
    output logic             power_good_oe,
    output logic [4:0]       core_rail_code,
    output logic [1:0]       card_rail_code,
    output logic [5:0]       rail_on
);
    pmsrp_sync_if s ();

    pmsrp_rst_e  rst_st_r;
    pmsrp_rst_e  rst_st_nxt;
    logic [31:0] rel_cnt_r;
    logic [31:0] rel_cnt_nxt;
    logic        mr_seen_r;
    logic        mr_seen_nxt;
    logic        aon_d_r;
    logic        aon_d_nxt;
    logic        rst_n_r;
    logic        rst_n_nxt;
    logic        rst_oe_r;
    logic        rst_oe_nxt;
    logic        db_oe_r;
    logic        db_oe_nxt;
    logic        db_n_r;
    logic        db_n_nxt;
    logic        lb_oe_r;
    logic        lb_oe_nxt;
    logic        lb_n_r;
    logic        lb_n_nxt;
    logic        pg_oe_r;
    logic        pg_oe_nxt;
    logic        pg_good;
    logic [4:0]  core_r;
    logic [4:0]  core_nxt;
    logic [1:0]  card_r;
    logic [1:0]  card_nxt;
    logic [7:0]  slew_r;
    logic [7:0]  slew_nxt;
    logic [5:0]  on_r;
    logic [5:0]  on_nxt;
    logic        mr_d_r;
    logic        mr_d_nxt;
    logic        ph_wr_r;
    logic        ph_wr_nxt;
    logic [11:0] ph_addr_r;
    logic [11:0] ph_addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        req;
    logic        mr_cause;
    logic        cause;

    // Every pin and comparator level passes two flops first
    pmsrp_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw     ({6'h00, rail_enable, rail_in_reg, low_batt_sense, dead_batt_sense, backup_supply,
                   manual_reset_n, always_on_rail_ok, vin_above_2v4, input_lockout}),
        .s       (s)
    );

    // Power-good sees only the six switchable rails
    pmsrp_pg #(.BLANK(PG_BLANK)) u_pg (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .s         (s),
        .core_slew (slew_r != 8'h00),
        .pg_good   (pg_good)
    );

    // Bus request in the address phase; every reply is one wait-free OKAY
    assign req = hsel && hready && htrans[1];

    // Release timer: held while a cause stands, then counts to terminal
    always_comb begin
        mr_cause    = !s.mr_n;
        cause       = mr_cause || !s.aon_ok; // RL3 RL6
        rst_st_nxt  = rst_st_r;
        rel_cnt_nxt = rel_cnt_r;
        mr_seen_nxt = mr_seen_r || mr_cause;
        aon_d_nxt   = s.aon_ok;
        case (rst_st_r)
            PMSRP_RST_HOLD: begin
                rel_cnt_nxt = 32'h0000_0000; // RL20
                if (!cause) begin
                    // Timer is unpowered in lockout, so an always-on rise then skips it
                    if (!mr_seen_r && (!s.vin_hi || !aon_d_r && s.lockout)) begin
                        rst_st_nxt = PMSRP_RST_OFF; // RL5
                    end else begin
                        rst_st_nxt = PMSRP_RST_COUNT; // RL4 RL21
                    end
                end
            end
            PMSRP_RST_COUNT: begin
                if (cause) begin
                    rst_st_nxt = PMSRP_RST_HOLD; // RL20
                end else if (rel_cnt_r >= REL_CYCLES - 1) begin
                    rst_st_nxt  = PMSRP_RST_OFF; // RL4 RL8
                    mr_seen_nxt = 1'b0;
                end else begin
                    rel_cnt_nxt = rel_cnt_r + 32'h0000_0001;
                end
            end
            PMSRP_RST_OFF: begin
                if (cause) begin
                    rst_st_nxt  = PMSRP_RST_HOLD;
                    mr_seen_nxt = mr_cause;
                end
            end
            default: rst_st_nxt = PMSRP_RST_HOLD;
        endcase
        rst_n_nxt  = (rst_st_nxt == PMSRP_RST_OFF); // RL3
        rst_oe_nxt = s.backup_ok; // RL7
        db_oe_nxt  = s.backup_ok; // RL7
        lb_oe_nxt  = s.backup_ok; // RL7
        pg_oe_nxt  = s.backup_ok; // RL7
        db_n_nxt   = s.lockout || !s.dead_cmp; // RL9 RL1
        lb_n_nxt   = s.lockout || !s.low_cmp; // RL10 RL1
    end

    // Settings, slew mask and bus data phase
    always_comb begin
        mr_d_nxt    = s.mr_n;
        core_nxt    = core_r;
        card_nxt    = card_r;
        slew_nxt    = (slew_r != 8'h00) ? slew_r - 8'h01 : 8'h00;
        on_nxt      = s.lockout ? 6'h00 : s.rail_en; // RL17 RL1
        ph_wr_nxt   = req && hwrite;
        ph_addr_nxt = req ? haddr[11:0] : ph_addr_r;
        rdata_nxt   = 32'h0000_0000;
        // Register writes are refused in lockout, but the stored values are kept
        if (ph_wr_r && !s.lockout) begin
            if (ph_addr_r == `PMSRP_ADDR_CORE) begin
                core_nxt = hwdata[4:0]; // RL18
                if (hwdata[4:0] != core_r) begin
                    slew_nxt = 8'(SLEW_CYC); // RL13
                end
            end else if (ph_addr_r == `PMSRP_ADDR_CARD) begin
                card_nxt = hwdata[1:0];
            end
        end
        if (!s.mr_n && mr_d_r) begin
            core_nxt = `PMSRP_CORE_DEF; // RL8 RL18 RL2
            card_nxt = `PMSRP_CARD_DEF; // RL8 RL19
            slew_nxt = 8'(SLEW_CYC);
        end
        if (req && !hwrite) begin
            if (haddr[11:0] == `PMSRP_ADDR_CTRL) begin
                rdata_nxt = {26'h000_0000, on_r};
            end else if (haddr[11:0] == `PMSRP_ADDR_CORE) begin
                rdata_nxt = {27'h000_0000, core_r};
            end else if (haddr[11:0] == `PMSRP_ADDR_CARD) begin
                rdata_nxt = {30'h0000_0000, card_r};
            end else if (haddr[11:0] == `PMSRP_ADDR_STATUS) begin
                rdata_nxt = {23'h00_0000, s.lockout, s.backup_ok, pg_good, !lb_n_r, !db_n_r,
                             rst_n_r, rst_st_r, slew_r != 8'h00};
            end else if (haddr[11:0] == `PMSRP_ADDR_ID) begin
                rdata_nxt = `PMSRP_ID_VALUE; // Arbitrary identification value
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_st_r  <= PMSRP_RST_HOLD;
            rel_cnt_r <= 32'h0000_0000;
            mr_seen_r <= 1'b0;
            aon_d_r   <= 1'b0;
            rst_n_r   <= 1'b0;
            rst_oe_r  <= 1'b0;
            db_oe_r   <= 1'b0;
            db_n_r    <= 1'b1;
            lb_oe_r   <= 1'b0;
            lb_n_r    <= 1'b1;
            pg_oe_r   <= 1'b0;
            core_r    <= `PMSRP_CORE_DEF;
            card_r    <= `PMSRP_CARD_DEF;
            slew_r    <= 8'h00;
            on_r      <= 6'h00;
            mr_d_r    <= 1'b1;
            ph_wr_r   <= 1'b0;
            ph_addr_r <= 12'h000;
            rdata_r   <= 32'h0000_0000;
        end else begin
            rst_st_r  <= rst_st_nxt;
            rel_cnt_r <= rel_cnt_nxt;
            mr_seen_r <= mr_seen_nxt;
            aon_d_r   <= aon_d_nxt;
            rst_n_r   <= rst_n_nxt;
            rst_oe_r  <= rst_oe_nxt;
            db_oe_r   <= db_oe_nxt;
            db_n_r    <= db_n_nxt;
            lb_oe_r   <= lb_oe_nxt;
            lb_n_r    <= lb_n_nxt;
            pg_oe_r   <= pg_oe_nxt;
            core_r    <= core_nxt;
            card_r    <= card_nxt;
            slew_r    <= slew_nxt;
            on_r      <= on_nxt;
            mr_d_r    <= mr_d_nxt;
            ph_wr_r   <= ph_wr_nxt;
            ph_addr_r <= ph_addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Open-drain power-good: drive low when not good and backup is present, release otherwise
    logic pg_drv_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pg_drv_r <= 1'b0;
        end else begin
            pg_drv_r <= pg_oe_nxt && !pg_good; // RL11 RL12 RL14 RL15 RL16
        end
    end

    assign hrdata              = rdata_r;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign reset_out_n_o       = rst_n_r;
    assign reset_out_n_oe      = rst_oe_r;
    assign dead_batt_flag_n_o  = db_n_r;
    assign dead_batt_flag_n_oe = db_oe_r;
    assign low_batt_flag_n_o   = lb_n_r;
    assign low_batt_flag_n_oe  = lb_oe_r;
    assign power_good_o        = 1'b0;
    assign power_good_oe       = pg_drv_r;
    assign core_rail_code      = core_r;
    assign card_rail_code      = card_r;
    assign rail_on             = on_r;
endmodule : pmsrp_top

// File: sim/pmsrp_host_model.sv
// Host processor stand-in: drives rail enables and manual reset after each edge
`timescale 1ns/100ps
module pmsrp_host (
    input  wire logic       hclk,
    input  wire logic [5:0] want_en,
    input  wire logic       want_mr_n,
    output logic      [5:0] rail_enable,
    output logic            manual_reset_n
);
    // Known levels before the first edge so the device never sees an unknown pin
    initial begin
        rail_enable    = 6'h00;
        manual_reset_n = 1'h1;
    end
    // Any ordering of rails is imposed here, never by the device itself
    always @(posedge hclk) begin
        rail_enable    <= want_en;
        manual_reset_n <= want_mr_n;
    end
endmodule : pmsrp_host

// File: sim/pmsrp_sup_assertions.sv
// Concurrent checks on the supervisor top ports
`timescale 1ns/100ps
`include "pmsrp_cfg.svh"
module pmsrp_chk #(
    parameter int unsigned REL_CYCLES = 20,
    parameter int unsigned PG_BLANK   = 8
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       input_lockout,
    input  wire logic       always_on_rail_ok,
    input  wire logic       manual_reset_n,
    input  wire logic       backup_supply,
    input  wire logic       dead_batt_sense,
    input  wire logic       low_batt_sense,
    input  wire logic [5:0] rail_in_reg,
    input  wire logic [5:0] rail_enable,
    input  wire logic       reset_out_n_o,
    input  wire logic       reset_out_n_oe,
    input  wire logic       dead_batt_flag_n_o,
    input  wire logic       dead_batt_flag_n_oe,
    input  wire logic       low_batt_flag_n_o,
    input  wire logic       low_batt_flag_n_oe,
    input  wire logic       power_good_oe,
    input  wire logic [4:0] core_rail_code,
    input  wire logic [1:0] card_rail_code,
    input  wire logic [5:0] rail_on
);
    int unsigned quiet_cnt;
    int unsigned ok_cnt;
    logic        mr_seen;
    logic        pg_ok_now;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Healthy power-good inputs: powered, not locked out, some rail on, all enabled rails good
    assign pg_ok_now = backup_supply && !input_lockout && (rail_enable != 6'h00) &&
                       ((rail_enable & ~rail_in_reg) == 6'h00);
    // Calm time since the last reset cause, and time the power-good inputs stayed healthy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_cnt <= 0;
            ok_cnt    <= 0;
            mr_seen   <= 1'h0;
        end else begin
            quiet_cnt <= (!manual_reset_n || !always_on_rail_ok) ? 0 : quiet_cnt + 1;
            ok_cnt    <= (pg_ok_now && $stable(rail_enable)) ? ok_cnt + 1 : 0;
            mr_seen   <= !manual_reset_n || (mr_seen && !reset_out_n_o);
        end
    end
    mr_low_a: assert property (!manual_reset_n [*5] |-> !reset_out_n_o)
        else $error("reset output high during manual reset");
    aon_low_a: assert property (!always_on_rail_ok [*5] |-> !reset_out_n_o)
        else $error("reset output high with always-on rail low");
    rel_hold_a: assert property ($rose(reset_out_n_o) && mr_seen |-> quiet_cnt >= REL_CYCLES)
        else $error("reset released before the full delay");
    rel_end_a: assert property (quiet_cnt == REL_CYCLES + 4 |-> reset_out_n_o)
        else $error("reset not released after the delay");
    no_rail_a: assert property ((backup_supply && rail_enable == 6'h00) [*5] |-> power_good_oe)
        else $error("power-good released with all rails off");
    lock_pg_a: assert property ((backup_supply && input_lockout) [*5] |-> power_good_oe)
        else $error("power-good released in lockout");
    rail_bad_a: assert property ((backup_supply && (rail_enable & ~rail_in_reg & 6'h3B) != 6'h00) [*5]
        |-> power_good_oe)
        else $error("power-good released with a rail out of regulation");
    pg_rel_a: assert property (ok_cnt > PG_BLANK + 5 |-> !power_good_oe)
        else $error("power-good held low with all rails good");
    no_bkp_a: assert property (!backup_supply [*5] |->
        !(reset_out_n_oe || power_good_oe || dead_batt_flag_n_oe || low_batt_flag_n_oe))
        else $error("output driven without backup supply");
    flags_a: assert property ((backup_supply && !input_lockout && dead_batt_sense && !low_batt_sense) [*5]
        |-> !dead_batt_flag_n_o && low_batt_flag_n_o)
        else $error("battery flags do not follow comparators");
    mr_dflt_a: assert property ($fell(manual_reset_n) |-> ##[2:5]
        (core_rail_code == `PMSRP_CORE_DEF && card_rail_code == `PMSRP_CARD_DEF))
        else $error("manual reset did not restore rail settings");
    follow_a: assert property ((!input_lockout && $stable(rail_enable)) [*5] |-> rail_on == rail_enable)
        else $error("rail output does not follow its enable");
endmodule : pmsrp_chk

// File: sim/tb_top.sv
// Self-checking bench for the supervisor: bus tasks, pin scenarios and verdict
`timescale 1ns/100ps
`include "pmsrp_cfg.svh"
module tb_top;
    localparam int unsigned REL = 20;
    localparam int unsigned BLK = 8;
    localparam int unsigned SLW = 16;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd_q;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        lock = 1'h0, vin = 1'h1, aon = 1'h1, bkp = 1'h1, dead = 1'h0, low = 1'h0, rdy_q;
    logic [5:0]  in_reg = 6'h00, want_en = 6'h00, rail_en, rail_on;
    logic        want_mr_n = 1'h1, mr_n, rst_o, rst_oe, db_o, db_oe, lb_o, lb_oe, pg_o, pg_oe;
    logic [4:0]  core;
    logic [1:0]  card;
    int          failures = 0, samples_checked = 0;
    // Released pins are pulled up on the board
    wire         rst_w = rst_oe ? rst_o : 1'h1;
    wire         pg_w = pg_oe ? pg_o : 1'h1;
    always #2.5 hclk = ~hclk;
    assign hready = hreadyout;
    // Bus answers captured with their pre-edge value to avoid an edge race
    always @(posedge hclk) begin
        rd_q  <= hrdata;
        rdy_q <= hreadyout;
    end
    pmsrp_top #(.REL_CYCLES(REL), .PG_BLANK(BLK), .SLEW_CYC(SLW)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .input_lockout(lock), .vin_above_2v4(vin), .always_on_rail_ok(aon), .manual_reset_n(mr_n),
        .backup_supply(bkp), .dead_batt_sense(dead), .low_batt_sense(low), .rail_in_reg(in_reg),
        .rail_enable(rail_en), .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe), .dead_batt_flag_n_o(db_o),
        .dead_batt_flag_n_oe(db_oe), .low_batt_flag_n_o(lb_o), .low_batt_flag_n_oe(lb_oe),
        .power_good_o(pg_o), .power_good_oe(pg_oe), .core_rail_code(core), .card_rail_code(card),
        .rail_on(rail_on));
    pmsrp_host host (.hclk(hclk), .want_en(want_en), .want_mr_n(want_mr_n), .rail_enable(rail_en),
        .manual_reset_n(mr_n));
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : wt
    // One single transfer: address phase, then data phase, each held until hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do wt(1); while (rdy_q !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do wt(1); while (rdy_q !== 1'h1);
        rd = rd_q;
    endtask : bus
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'h0, a, 32'h0000_0000, d);
        check(nm, d, exp);
    endtask : rchk
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #10000;
        failures++;
        final_report();
    end
    // Main sequence
    initial begin
        logic [31:0] d;
        wt(8);
        hresetn <= 1'h1;
        wt(REL + 10);
        check("rst_boot", 32'(rst_w), 32'h0000_0001);
        rchk("core_def", `PMSRP_ADDR_CORE, 32'h0000_0018);
        rchk("card_def", `PMSRP_ADDR_CARD, 32'h0000_0000);
        rchk("unmapped", 32'h0000_0020, 32'h0000_0000);
        check("pg_none", 32'(pg_w), 32'h0000_0000);
        want_en <= 6'h3F;
        wt(5);
        check("pg_bad", 32'(pg_w), 32'h0000_0000);
        check("rails", 32'(rail_on), 32'h0000_003F);
        rchk("rail_reg", `PMSRP_ADDR_CTRL, 32'h0000_003F);
        in_reg <= 6'h3F;
        wt(BLK + 8);
        check("pg_ok", 32'(pg_w), 32'h0000_0001);
        aon <= 1'h0;
        wt(5);
        check("pg_aon", 32'(pg_w), 32'h0000_0001);
        check("rst_aon", 32'(rst_w), 32'h0000_0000);
        aon <= 1'h1;
        wt(REL - 2);
        check("rst_hold", 32'(rst_w), 32'h0000_0000);
        wt(12);
        check("rst_rel", 32'(rst_w), 32'h0000_0001);
        in_reg <= 6'h3E;
        wt(5);
        check("pg_io", 32'(pg_w), 32'h0000_0000);
        check("rst_io", 32'(rst_w), 32'h0000_0001);
        want_en <= 6'h3E;
        wt(BLK + 8);
        check("pg_off", 32'(pg_w), 32'h0000_0001);
        in_reg <= 6'h3F;
        want_en <= 6'h3F;
        wt(7);
        check("pg_blank", 32'(pg_w), 32'h0000_0000);
        wt(BLK + 6);
        check("pg_back", 32'(pg_w), 32'h0000_0001);
        bus(1'h1, `PMSRP_ADDR_CORE, 32'h0000_0005, d);
        in_reg <= 6'h3B;
        wt(5);
        check("pg_slew", 32'(pg_w), 32'h0000_0001);
        wt(SLW + 6);
        check("pg_core", 32'(pg_w), 32'h0000_0000);
        in_reg <= 6'h3F;
        vin <= 1'h0;
        aon <= 1'h0;
        wt(5);
        aon <= 1'h1;
        wt(6);
        check("rst_fast", 32'(rst_w), 32'h0000_0001);
        vin <= 1'h1;
        bus(1'h1, `PMSRP_ADDR_CARD, 32'h0000_0003, d);
        rchk("core_rw", `PMSRP_ADDR_CORE, 32'h0000_0005);
        want_mr_n <= 1'h0;
        wt(2 * REL);
        check("rst_mr", 32'(rst_w), 32'h0000_0000);
        check("core_mr", 32'(core), 32'h0000_0018);
        check("card_mr", 32'(card), 32'h0000_0000);
        check("rails_mr", 32'(rail_on), 32'h0000_003F);
        want_mr_n <= 1'h1;
        wt(REL - 2);
        check("rst_mr_hold", 32'(rst_w), 32'h0000_0000);
        wt(12);
        check("rst_mr_rel", 32'(rst_w), 32'h0000_0001);
        dead <= 1'h1;
        wt(5);
        check("dead", 32'(db_o), 32'h0000_0000);
        check("low_idle", 32'(lb_o), 32'h0000_0001);
        low <= 1'h1;
        wt(5);
        check("low", 32'(lb_o), 32'h0000_0000);
        lock <= 1'h1;
        wt(5);
        check("pg_lock", 32'(pg_w), 32'h0000_0000);
        check("rails_lock", 32'(rail_on), 32'h0000_0000);
        bus(1'h1, `PMSRP_ADDR_CORE, 32'h0000_0007, d);
        rchk("core_lock", `PMSRP_ADDR_CORE, 32'h0000_0018);
        check("lock_resp", 32'(hresp), 32'h0000_0000);
        rchk("status_lock", `PMSRP_ADDR_STATUS, 32'h0000_018C);
        lock <= 1'h0;
        bkp <= 1'h0;
        wt(5);
        check("oe_off", 32'({rst_oe, db_oe, lb_oe, pg_oe}), 32'h0000_0000);
        final_report();
    end
endmodule : tb_top
bind pmsrp_top pmsrp_chk #(.REL_CYCLES(REL_CYCLES), .PG_BLANK(PG_BLANK)) chk (.*);
